// file: hiel_pkg.sv
// Purpose: Shared constants for the host event flag and interrupt enable logic
// Assumes: 100 MHz clock, word-addressed register map with byte offsets
// Notes:   Offsets are byte addresses; all registers are 32 bits wide
`default_nettype none
package hiel_pkg;

  // Register bus shape
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 32;

  // Register offsets
  localparam logic [15:0] STATUS_OFS      = 16'h0310;
  localparam logic [15:0] ENABLE_OFS      = 16'h0314;

  // Event bit positions, shared by status and enable registers
  localparam int unsigned BIT_RSVD_LO     = 0;
  localparam int unsigned BIT_FRAME_START = 1;
  localparam int unsigned BIT_RSVD_HI     = 2;
  localparam int unsigned BIT_DMA_FINISH  = 3;
  localparam int unsigned BIT_SUSPEND     = 5;
  localparam int unsigned BIT_CLK_STABLE  = 6;
  localparam int unsigned BIT_PERIODIC    = 7;
  localparam int unsigned BIT_ASYNC_LIST  = 8;
  localparam int unsigned BIT_ISO         = 9;

  // Field masks and reset values
  localparam logic [31:0] EVENT_MASK      = 32'h0000_03ea;
  localparam logic [31:0] RSVD_MASK       = 32'h0000_0005;
  localparam logic [31:0] ENABLE_RESET    = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

  // Timing: reserved status bits rise this long after reset release
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned RSVD_SETTLE_NS  = 1000;
  localparam int unsigned RSVD_SETTLE_CYC =
    (RSVD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CNT_W    = 12;

  // Reserved-bit settle sequencer
  typedef enum logic [1:0] {
    HIEL_SETTLING = 2'b01,
    HIEL_READY    = 2'b10
  } hiel_rsvd_state_type;

endpackage : hiel_pkg
`default_nettype wire

// file: hiel_top.sv
// Purpose: Event flags and per-event enables driving one interrupt line
// Assumes: Event inputs synchronous to clk; descriptor masks applied upstream
// Notes:   Status flags clear by writing one; a new event beats the clear
//
// Function
// - Frame start event sets status bit 1; reads zero otherwise.
// - Reserved status bits 0 and 2 read zero after reset, later one.
// - Enable register at 0x314, 32 bits read/write, reset clears all.
// - Enable bit 9 lets isochronous completions raise the interrupt line.
// - Enable bit 8 lets async-list completions raise the interrupt line.
// - Enable bit 7 lets periodic-poll completions raise the interrupt line.
// - Enable bit 6 lets clocks-stable raise the interrupt line.
// - Enable bit 5 lets suspend entry raise the interrupt line.
// - Enable bit 3 lets DMA completion raise the interrupt line.
// - Enable bit 1 lets every frame start raise the interrupt line.
// - Descriptor completions set status bits 9, 8 and 7.
// - Clocks stable sets bit 6, suspend bit 5, DMA finish bit 3.
`timescale 1ns/10ps
`default_nettype none

module hiel_top
  import hiel_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = RSVD_SETTLE_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [hiel_pkg::ADDR_W-1:0]  addr,
  input  wire logic [hiel_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output logic      [hiel_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                         iso_done,
  input  wire logic                         async_list_done,
  input  wire logic                         periodic_done,
  input  wire logic                         clocks_stable,
  input  wire logic                         suspend_active,
  input  wire logic                         dma_finish,
  input  wire logic                         frame_start,
  output logic                              irq
);

  import hiel_pkg::*;

  logic [DATA_W-1:0]       enable_reg;
  logic [DATA_W-1:0]       status_vec;
  logic [DATA_W-1:0]       event_vec;
  logic [DATA_W-1:0]       clear_vec;
  logic [DATA_W-1:0]       rd_data_reg;
  logic [DATA_W-1:0]       rd_data_next;
  logic                    irq_reg;
  logic                    irq_next;
  logic                    clk_stable_prev_reg;
  logic                    suspend_prev_reg;
  logic [SETTLE_CNT_W-1:0] settle_cnt_reg;
  logic                    sel_status;
  logic                    sel_enable;
  hiel_rsvd_state_type     rsvd_state_reg;

  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST =
    SETTLE_CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [SETTLE_CNT_W-1:0] CNT_ONE  = SETTLE_CNT_W'(1);
  localparam logic [SETTLE_CNT_W-1:0] CNT_ZERO = SETTLE_CNT_W'(0);

  assign sel_status = (addr == STATUS_OFS);
  assign sel_enable = (addr == ENABLE_OFS);

  // Detectors reset low, so a level high at release counts as an edge
  // level inputs become edge events
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_stable_prev_reg <= 1'b0;
      suspend_prev_reg    <= 1'b0;
    end else begin
      clk_stable_prev_reg <= clocks_stable;
      suspend_prev_reg    <= suspend_active;
    end
  end

  always_comb begin
    event_vec                  = READ_ZERO;
    event_vec[BIT_ISO]         = iso_done;
    event_vec[BIT_ASYNC_LIST]  = async_list_done;
    event_vec[BIT_PERIODIC]    = periodic_done;
    event_vec[BIT_CLK_STABLE]  = clocks_stable & ~clk_stable_prev_reg;
    event_vec[BIT_SUSPEND]     = suspend_active & ~suspend_prev_reg;
    event_vec[BIT_DMA_FINISH]  = dma_finish;
    event_vec[BIT_FRAME_START] = frame_start;
  end

  assign clear_vec = (wr_en && sel_status) ? wr_data : READ_ZERO;

  // Sticky event flags; unused positions read zero
  generate
    for (genvar i = 0; i < DATA_W; i++) begin : g_flag
      if (EVENT_MASK[i]) begin : g_evt
        logic flag_reg;
        always_ff @(posedge clk) begin
          if (rst) begin
            flag_reg <= 1'b0;
          end else if (event_vec[i]) begin
            flag_reg <= 1'b1;
          end else if (clear_vec[i]) begin
            flag_reg <= 1'b0;
          end
        end
        assign status_vec[i] = flag_reg;
        flag_set_a: assert property (
          @(posedge clk) disable iff (rst)
          event_vec[i] |=> flag_reg)
          else $error("event flag not set after event");
        flag_clear_a: assert property (
          @(posedge clk) disable iff (rst)
          clear_vec[i] && !event_vec[i] |=> !flag_reg)
          else $error("event flag not cleared by write");
      end else if (RSVD_MASK[i]) begin : g_rsvd
        assign status_vec[i] = (rsvd_state_reg == HIEL_READY);
      end else begin : g_zero
        assign status_vec[i] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      rsvd_state_reg <= HIEL_SETTLING;
      settle_cnt_reg <= CNT_ZERO;
    end else begin
      unique case (rsvd_state_reg)
        HIEL_SETTLING: begin
          if (settle_cnt_reg == SETTLE_LAST) begin
            rsvd_state_reg <= HIEL_READY;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + CNT_ONE;
          end
        end
        HIEL_READY: begin
          rsvd_state_reg <= HIEL_READY;
        end
        default: begin
          rsvd_state_reg <= HIEL_SETTLING;
          settle_cnt_reg <= CNT_ZERO;
        end
      endcase
    end
  end

  // reserved bits kept as written; software writes zero
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg <= ENABLE_RESET;
    end else if (wr_en && sel_enable) begin
      enable_reg <= wr_data;
    end
  end

  // gated line
  // Mask with event bits so stray reserved enables cannot fire the line
  assign irq_next = |(status_vec & enable_reg & EVENT_MASK);

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Registered read keeps rd_data straight from a flop
  // Read mux; unmapped addresses answer zero
  always_comb begin
    rd_data_next = READ_ZERO;
    if (rd_en && sel_status) begin
      rd_data_next = status_vec;
    end else if (rd_en && sel_enable) begin
      rd_data_next = enable_reg;
    end
  end

  // Data stands one cycle only, zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_reg <= READ_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign irq     = irq_reg;

  // Checks

  frame_flag_set_a: assert property (
    @(posedge clk) disable iff (rst)
    frame_start |=> status_vec[BIT_FRAME_START])
    else $error("frame start flag not set after event");

  rsvd_low_early_a: assert property (
    @(posedge clk)
    $past(rst) && !rst |-> (status_vec & RSVD_MASK) == READ_ZERO)
    else $error("reserved status bits not zero after reset");

  rsvd_rise_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(rsvd_state_reg == HIEL_READY) |->
      (status_vec & RSVD_MASK) == RSVD_MASK &&
      $past(settle_cnt_reg) == SETTLE_LAST)
    else $error("reserved status bits rose at wrong time");

  rsvd_stay_a: assert property (
    @(posedge clk) disable iff (rst)
    rsvd_state_reg == HIEL_READY |=> (status_vec & RSVD_MASK) == RSVD_MASK)
    else $error("reserved status bits fell after settling");

  enable_write_a: assert property (
    @(posedge clk) disable iff (rst)
    wr_en && sel_enable |=> enable_reg == $past(wr_data))
    else $error("enable register did not take written value");

  enable_reset_a: assert property (
    @(posedge clk)
    rst |=> enable_reg == ENABLE_RESET && !irq && rd_data == READ_ZERO)
    else $error("enable register not cleared by reset");

  iso_irq_a: assert property (
    @(posedge clk) disable iff (rst)
    iso_done && enable_reg[BIT_ISO] && !(wr_en && sel_enable)
      |-> ##2 irq)
    else $error("isochronous completion did not raise line");

  async_irq_a: assert property (
    @(posedge clk) disable iff (rst)
    async_list_done && enable_reg[BIT_ASYNC_LIST] &&
      !(wr_en && sel_enable) |-> ##2 irq)
    else $error("async list completion did not raise line");

  dma_irq_a: assert property (
    @(posedge clk) disable iff (rst)
    dma_finish && enable_reg[BIT_DMA_FINISH] &&
      !(wr_en && sel_enable) |-> ##2 irq)
    else $error("DMA completion did not raise line");

  periodic_irq_a: assert property (
    @(posedge clk) disable iff (rst)
    periodic_done && enable_reg[BIT_PERIODIC] &&
      !(wr_en && sel_enable) |-> ##2 irq)
    else $error("periodic completion did not raise line");

  clk_stable_irq_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(clocks_stable) && enable_reg[BIT_CLK_STABLE] &&
      !(wr_en && sel_enable) |-> ##2 irq)
    else $error("clocks stable did not raise line");

  suspend_irq_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(suspend_active) && enable_reg[BIT_SUSPEND] &&
      !(wr_en && sel_enable) |-> ##2 irq)
    else $error("suspend entry did not raise line");

  frame_irq_a: assert property (
    @(posedge clk) disable iff (rst)
    frame_start && enable_reg[BIT_FRAME_START] &&
      !(wr_en && sel_enable) |-> ##2 irq)
    else $error("frame start did not raise line");

  periodic_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    periodic_done |=> status_vec[BIT_PERIODIC])
    else $error("periodic flag not set after completion");

  clk_stable_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(clocks_stable) |=> status_vec[BIT_CLK_STABLE])
    else $error("clocks stable flag not set");

  iso_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    iso_done |=> status_vec[BIT_ISO])
    else $error("isochronous flag not set after completion");

  async_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    async_list_done |=> status_vec[BIT_ASYNC_LIST])
    else $error("async list flag not set after completion");

  suspend_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(suspend_active) |=> status_vec[BIT_SUSPEND])
    else $error("suspend flag not set");

  dma_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    dma_finish |=> status_vec[BIT_DMA_FINISH])
    else $error("DMA finish flag not set");

  line_quiet_a: assert property (
    @(posedge clk) disable iff (rst)
    (status_vec & enable_reg & EVENT_MASK) == READ_ZERO |=> !irq)
    else $error("line active with no enabled flag");

  line_on_a: assert property (
    @(posedge clk) disable iff (rst)
    (status_vec & enable_reg & EVENT_MASK) != READ_ZERO |=> irq)
    else $error("line quiet with an enabled flag set");

  rd_data_idle_a: assert property (
    @(posedge clk) disable iff (rst)
    !rd_en |=> rd_data == READ_ZERO)
    else $error("read data stood without a read");

  suspend_off_a: assert property (
    @(posedge clk) disable iff (rst)
    status_vec[BIT_SUSPEND] && !enable_reg[BIT_SUSPEND] &&
      (status_vec & enable_reg & EVENT_MASK) == READ_ZERO |=> !irq)
    else $error("disabled suspend flag raised line");

endmodule : hiel_top
`default_nettype wire

// file: hiel_host.sv
// Purpose: Processor-side model driving the register port
// Assumes: Strobes one cycle long, read data one cycle after rd_en
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module hiel_host
  import hiel_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wr_data,
  output logic                   wr_en,
  output logic                   rd_en
);
  initial begin
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = (a == ENABLE_OFS) ? (d & EVENT_MASK) : d;
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~v;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1 d = rd_data;
  endtask : rd
endmodule : hiel_host
`default_nettype wire

// file: hiel_top_test.sv
// Purpose: Self-checking bench for the event flag and enable logic
// Assumes: Settle count shortened to 4 cycles
// Notes:   Random events and enables, seeded once
`timescale 1ns/10ps
`default_nettype none
module hiel_top_test;
  import hiel_pkg::*;
  localparam int unsigned SETTLE = 4;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic              rd_en;
  logic [6:0]        ev = '0;
  logic              irq;
  int                n_mismatch = 0;
  int                n_tests = 0;
  always #5 clk = ~clk;
  hiel_host i_host (.clk(clk), .rd_data(rd_data), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en));
  hiel_top #(.SETTLE_CYCLES(SETTLE)) i_dut (.clk(clk), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .iso_done(ev[6]), .async_list_done(ev[5]),
    .periodic_done(ev[4]), .clocks_stable(ev[3]),
    .suspend_active(ev[2]), .dma_finish(ev[1]), .frame_start(ev[0]),
    .irq(irq));
  // Event vector order to status bit positions
  function automatic logic [31:0] flags_of(input logic [6:0] e);
    logic [31:0] f;
    f = '0;
    f[BIT_FRAME_START] = e[0];
    f[BIT_DMA_FINISH] = e[1];
    f[BIT_SUSPEND] = e[2];
    f[BIT_CLK_STABLE] = e[3];
    f[BIT_PERIODIC] = e[4];
    f[BIT_ASYNC_LIST] = e[5];
    f[BIT_ISO] = e[6];
    return f;
  endfunction : flags_of
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] en;
    logic [6:0]  e;
    void'($urandom(32'h0b634cd8));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    i_host.rd(STATUS_OFS, d);
    chk(d, READ_ZERO, "status after reset");
    i_host.rd(ENABLE_OFS, d);
    chk(d, ENABLE_RESET, "enable after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    repeat (SETTLE) @(posedge clk);
    i_host.rd(STATUS_OFS, d);
    chk(d, RSVD_MASK, "reserved bits settled");
    i_host.rd(16'h0318, d);
    chk(d, READ_ZERO, "unmapped read");
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
      en = (i < 8) ? 32'h0 : (i < 16) ? EVENT_MASK : $urandom() & EVENT_MASK;
      e = (i < 16) ? 7'(1 << (i % 7)) : 7'($urandom());
      i_host.wr(ENABLE_OFS, en);
      i_host.rd(ENABLE_OFS, d);
      chk(d, en, "enable readback");
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
      @(posedge clk);
      #1 chk({31'h0, irq}, {31'h0, |(flags_of(e) & en)}, "irq");
      i_host.rd(STATUS_OFS, d);
      chk(d, flags_of(e) | RSVD_MASK, "status flags");
      fork
        i_host.wr(STATUS_OFS, flags_of(e));
        begin
          @(posedge clk);
          ev <= e;
          @(posedge clk);
          ev <= '0;
        end
      join
      i_host.rd(STATUS_OFS, d);
      chk(d, flags_of(e) | RSVD_MASK, "set beats clear");
      i_host.wr(STATUS_OFS, flags_of(e));
      @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0, "irq after clear");
      i_host.rd(STATUS_OFS, d);
      chk(d, RSVD_MASK, "status cleared");
    end
    $display("test events done");
    i_host.wr(ENABLE_OFS, EVENT_MASK);
    @(posedge clk);
    ev <= 7'h7f;
    @(posedge clk);
    ev <= '0;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    i_host.rd(STATUS_OFS, d);
    chk(d, READ_ZERO, "status after second reset");
    i_host.rd(ENABLE_OFS, d);
    chk(d, ENABLE_RESET, "enable after second reset");
    chk({31'h0, irq}, 32'h0, "irq after second reset");
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : hiel_top_test
`default_nettype wire
